/* File: verilog/rsm_pkg.sv */
package rsm_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int RSM_ADDR_W = 8;
  localparam int RSM_DATA_W = 32;
  localparam int RSM_CNT_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RSM_OFF_STATUS = 8'h00;
  localparam logic [7:0] RSM_OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] RSM_OFF_CTRL = 8'h08;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int RSM_BIT_CAS_LOCK = 4;
  localparam int RSM_BIT_CRC_LOCK = 3;
  localparam int RSM_BIT_OVERFLOW = 2;
  localparam int RSM_BIT_UNDERFLOW = 1;
  localparam int RSM_BIT_SLIP = 0;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int RSM_BIT_CAS_EN = 0;
  localparam int RSM_BIT_CRC_EN = 1;
  localparam int RSM_POS_CAS_LOSS = 4;
  localparam int RSM_POS_CRC_DECL = 8;
  localparam int RSM_POS_CRC_LOSS = 12;
  localparam int RSM_POS_CAS_DECL = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RSM_RST_IRQ_MASK = 3'h0;
  localparam logic RSM_RST_CAS_EN = 1'b1;
  localparam logic RSM_RST_CRC_EN = 1'b1;
  localparam logic [3:0] RSM_RST_CAS_LOSS = 4'h2;
  localparam logic [3:0] RSM_RST_CAS_DECL = 4'h1;
  localparam logic [3:0] RSM_RST_CRC_DECL = 4'h2;
  localparam logic [3:0] RSM_RST_CRC_LOSS = 4'h2;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RSM_RESP_OKAY = 2'b00;
  localparam logic [1:0] RSM_RESP_SLVERR = 2'b10;

endpackage

/* File: verilog/rsm_lock_tracker.sv */
`timescale 1ns/1ps
// Multiframe alignment tracker: counts consecutive good alignment words to
// declare lock and consecutive errored ones to declare loss of lock.
module rsm_lock_tracker
  import rsm_pkg::*;
#(
  parameter int CNT_W = RSM_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic ok_i,
  input wire logic err_i,
  input wire logic [CNT_W-1:0] decl_count_i,
  input wire logic [CNT_W-1:0] loss_count_i,
  output logic locked_o
);

  typedef struct packed {
    logic locked;
    logic [CNT_W-1:0] run;
  } rsm_trk_state_t;

  rsm_trk_state_t s;
  rsm_trk_state_t next_s;
  logic [CNT_W:0] run_inc;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // An errored word wins over a good one in the same cycle; a count of
  // zero behaves like one so the tracker can never stall.
  always_comb begin
    next_s = s;
    run_inc = {1'b0, s.run} + {{CNT_W{1'b0}}, 1'b1};
    if (!enable_i) begin
      next_s = '0;
    end else if (!s.locked) begin
      if (err_i) begin
        next_s.run = '0;
      end else if (ok_i) begin
        if (run_inc >= {1'b0, decl_count_i}) begin
          next_s.locked = 1'b1;
          next_s.run = '0;
        end else begin
          next_s.run = run_inc[CNT_W-1:0];
        end
      end
    end else begin
      if (err_i) begin
        if (run_inc >= {1'b0, loss_count_i}) begin
          next_s.locked = 1'b0;
          next_s.run = '0;
        end else begin
          next_s.run = run_inc[CNT_W-1:0];
        end
      end else if (ok_i) begin
        next_s.run = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign locked_o = s.locked;

endmodule // rsm_lock_tracker

/* File: verilog/rsm_status_regs.sv */
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - Bit 4 shows live CAS multiframe lock
// - CAS lock lost after configured errored words
// - CAS lock bit meaningless with signaling off
// - Bit 3 shows live CRC multiframe lock
// - CRC lock bit meaningless with alignment off
// - Write when full deletes frame, sets bit 2
// - Read when empty repeats frame, sets bit 1
// - Either slip event sets bit 0
// - Reading status clears the three slip bits
module rsm_status_regs
  import rsm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [RSM_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [RSM_DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [RSM_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [RSM_DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic CAS_ALIGN_OK_I,
  input wire logic CAS_ALIGN_ERR_I,
  input wire logic CRC_ALIGN_OK_I,
  input wire logic CRC_ALIGN_ERR_I,
  input wire logic RX_SLIP_WRITE_I,
  input wire logic RX_SLIP_READ_I,
  input wire logic RX_SLIP_FULL_I,
  input wire logic RX_SLIP_EMPTY_I,
  output logic RX_FRAME_DELETE_O,
  output logic RX_FRAME_REPEAT_O,
  output logic IRQ_O
);

  typedef struct packed {
    logic aw_held;
    logic [RSM_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [RSM_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [RSM_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic overflow;
    logic underflow;
    logic slip;
    logic [2:0] irq_mask;
    logic cas_en;
    logic crc_en;
    logic [3:0] cas_loss;
    logic [3:0] cas_decl;
    logic [3:0] crc_decl;
    logic [3:0] crc_loss;
    logic delete_frame;
    logic repeat_frame;
  } rsm_top_state_t;

  rsm_top_state_t s;
  rsm_top_state_t next_s;
  logic cas_lock;
  logic crc_lock;
  logic ovf_evt;
  logic unf_evt;
  logic ar_take;
  logic wr_commit;
  logic rd_clear;
  logic [2:0] w1c;
  logic [RSM_DATA_W-1:0] ctrl_word;
  logic [RSM_DATA_W-1:0] ctrl_merged;

  // Word-aligned address match, used by both read and write decode
  function automatic logic addr_hit(input logic [RSM_ADDR_W-1:0] a,
                                    input logic [7:0] off);
    addr_hit = (a[RSM_ADDR_W-1:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // Multiframe lock trackers
  // ----------------------------------------------------------------
  // Disabling a tracker forces it unlocked; the bit then has no meaning
  rsm_lock_tracker #(.CNT_W(RSM_CNT_W)) u_cas_trk (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .enable_i(s.cas_en),
    .ok_i(CAS_ALIGN_OK_I),
    .err_i(CAS_ALIGN_ERR_I),
    .decl_count_i(s.cas_decl),
    .loss_count_i(s.cas_loss),
    .locked_o(cas_lock)
  );

  rsm_lock_tracker #(.CNT_W(RSM_CNT_W)) u_crc_trk (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .enable_i(s.crc_en),
    .ok_i(CRC_ALIGN_OK_I),
    .err_i(CRC_ALIGN_ERR_I),
    .decl_count_i(s.crc_decl),
    .loss_count_i(s.crc_loss),
    .locked_o(crc_lock)
  );

  // ----------------------------------------------------------------
  // Slip events and bus handshakes
  // ----------------------------------------------------------------
  assign ovf_evt = RX_SLIP_WRITE_I & RX_SLIP_FULL_I;
  assign unf_evt = RX_SLIP_READ_I & RX_SLIP_EMPTY_I;
  // Readies are gated by the enable so no beat is taken while frozen
  assign AWREADY = CE_I & ~s.aw_held;
  assign WREADY = CE_I & ~s.w_held;
  assign ARREADY = CE_I & ~s.rvalid;
  assign ar_take = ARVALID & ARREADY;
  assign wr_commit = s.aw_held & s.w_held & ~s.bvalid;
  assign rd_clear = ar_take & addr_hit(ARADDR, RSM_OFF_STATUS);
  assign w1c = (wr_commit & addr_hit(s.aw_addr, RSM_OFF_STATUS)
                & s.w_strb[0]) ? s.w_data[2:0] : 3'h0;
  assign ctrl_word = {12'h000, s.cas_decl, s.crc_loss, s.crc_decl,
                      s.cas_loss, 2'b00, s.crc_en, s.cas_en};

  // Byte-lane merge of a control write over the current control word
  always_comb begin
    ctrl_merged = ctrl_word;
    for (int i = 0; i < 4; i++) begin
      if (s.w_strb[i]) begin
        ctrl_merged[i*8 +: 8] = s.w_data[i*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sticky bits: a new event in the clearing cycle wins over the clear
  always_comb begin
    next_s = s;
    next_s.delete_frame = ovf_evt;
    next_s.repeat_frame = unf_evt;
    // Write address and data are captured independently
    if (AWVALID && AWREADY) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_s.w_held = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RSM_RESP_OKAY;
      if (addr_hit(s.aw_addr, RSM_OFF_IRQ_MASK)) begin
        if (s.w_strb[0]) begin
          next_s.irq_mask = s.w_data[2:0];
        end
      end else if (addr_hit(s.aw_addr, RSM_OFF_CTRL)) begin
        next_s.cas_en = ctrl_merged[RSM_BIT_CAS_EN];
        next_s.crc_en = ctrl_merged[RSM_BIT_CRC_EN];
        next_s.cas_loss = ctrl_merged[RSM_POS_CAS_LOSS +: 4];
        next_s.crc_decl = ctrl_merged[RSM_POS_CRC_DECL +: 4];
        next_s.crc_loss = ctrl_merged[RSM_POS_CRC_LOSS +: 4];
        next_s.cas_decl = ctrl_merged[RSM_POS_CAS_DECL +: 4];
      end else if (!addr_hit(s.aw_addr, RSM_OFF_STATUS)) begin
        next_s.bresp = RSM_RESP_SLVERR;
      end
    end
    // Read path: data captured at address acceptance
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RSM_RESP_OKAY;
      next_s.rdata = '0;
      if (addr_hit(ARADDR, RSM_OFF_STATUS)) begin
        next_s.rdata[RSM_BIT_CAS_LOCK] = cas_lock;
        next_s.rdata[RSM_BIT_CRC_LOCK] = crc_lock;
        next_s.rdata[RSM_BIT_OVERFLOW] = s.overflow;
        next_s.rdata[RSM_BIT_UNDERFLOW] = s.underflow;
        next_s.rdata[RSM_BIT_SLIP] = s.slip;
      end else if (addr_hit(ARADDR, RSM_OFF_IRQ_MASK)) begin
        next_s.rdata[2:0] = s.irq_mask;
      end else if (addr_hit(ARADDR, RSM_OFF_CTRL)) begin
        next_s.rdata = ctrl_word;
      end else begin
        next_s.rresp = RSM_RESP_SLVERR;
      end
    end
    // Clear on read or write-one, then set from this cycle's events
    next_s.overflow = (s.overflow & ~rd_clear & ~w1c[RSM_BIT_OVERFLOW])
                      | ovf_evt;
    next_s.underflow = (s.underflow & ~rd_clear & ~w1c[RSM_BIT_UNDERFLOW])
                       | unf_evt;
    next_s.slip = (s.slip & ~rd_clear & ~w1c[RSM_BIT_SLIP])
                  | ovf_evt | unf_evt;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything resets to zero status; control takes its defaults
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s <= '0;
      s.irq_mask <= RSM_RST_IRQ_MASK;
      s.cas_en <= RSM_RST_CAS_EN;
      s.crc_en <= RSM_RST_CRC_EN;
      s.cas_loss <= RSM_RST_CAS_LOSS;
      s.cas_decl <= RSM_RST_CAS_DECL;
      s.crc_decl <= RSM_RST_CRC_DECL;
      s.crc_loss <= RSM_RST_CRC_LOSS;
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign RX_FRAME_DELETE_O = s.delete_frame;
  assign RX_FRAME_REPEAT_O = s.repeat_frame;
  // Level interrupt; only the sticky slip bits can raise it
  assign IRQ_O = |({s.overflow, s.underflow, s.slip} & s.irq_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_overflow_set: assert property (
    CE_I && RX_SLIP_WRITE_I && RX_SLIP_FULL_I
      |=> s.overflow && RX_FRAME_DELETE_O)
    else $error("overflow event not recorded");

  a_underflow_set: assert property (
    CE_I && RX_SLIP_READ_I && RX_SLIP_EMPTY_I
      |=> s.underflow && RX_FRAME_REPEAT_O)
    else $error("underflow event not recorded");

  a_slip_any: assert property (
    CE_I && (ovf_evt || unf_evt) |=> s.slip)
    else $error("slip bit missed an event");

  a_slip_cause: assert property (
    $rose(s.slip) |-> $past(ovf_evt) || $past(unf_evt))
    else $error("slip bit set without an event");

  a_read_clears: assert property (
    CE_I && ARVALID && ARREADY && addr_hit(ARADDR, RSM_OFF_STATUS)
      && !ovf_evt && !unf_evt
      |=> !s.overflow && !s.underflow && !s.slip)
    else $error("status read did not clear slip bits");

  a_read_reports: assert property (
    CE_I && ARVALID && ARREADY && addr_hit(ARADDR, RSM_OFF_STATUS)
      |=> RVALID && RDATA[4] == $past(cas_lock)
          && RDATA[3] == $past(crc_lock))
    else $error("lock bits misreported");

  a_cas_off: assert property (
    CE_I && !s.cas_en |=> !cas_lock)
    else $error("CAS lock held while signaling disabled");

  a_crc_off: assert property (
    CE_I && !s.crc_en |=> !crc_lock)
    else $error("CRC lock held while alignment disabled");

  a_cas_loss: assert property (
    CE_I && cas_lock && s.cas_en && s.cas_loss == 4'h1 && CAS_ALIGN_ERR_I
      |=> !cas_lock)
    else $error("CAS lock kept past the error limit");

  a_rvalid_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped before taken");

endmodule // rsm_status_regs

/* File: bench/test_rx_slip_and_multiframe_status.sv */
`timescale 1ns/1ps
module test_rx_slip_and_multiframe_status;
  import rsm_pkg::*;

  // ------------------------------------------------------------
  // Design ports and bench state
  // ------------------------------------------------------------
  logic CLK_I, RST_I, CE_I;
  logic [RSM_ADDR_W-1:0] AWADDR, ARADDR;
  logic [2:0] AWPROT, ARPROT;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic [RSM_DATA_W-1:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic CAS_ALIGN_OK_I, CAS_ALIGN_ERR_I, CRC_ALIGN_OK_I, CRC_ALIGN_ERR_I;
  logic RX_SLIP_WRITE_I, RX_SLIP_READ_I, RX_SLIP_FULL_I, RX_SLIP_EMPTY_I;
  logic RX_FRAME_DELETE_O, RX_FRAME_REPEAT_O, IRQ_O;
  int err_count, num_checks, cyc, seed;
  logic [2:0] exp_sticky;
  logic rd_slow;

  rsm_status_regs dut (
    .CLK_I, .RST_I, .CE_I, .AWADDR, .AWPROT, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARPROT, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .CAS_ALIGN_OK_I, .CAS_ALIGN_ERR_I, .CRC_ALIGN_OK_I,
    .CRC_ALIGN_ERR_I, .RX_SLIP_WRITE_I, .RX_SLIP_READ_I,
    .RX_SLIP_FULL_I, .RX_SLIP_EMPTY_I, .RX_FRAME_DELETE_O,
    .RX_FRAME_REPEAT_O, .IRQ_O
  );

  // 100 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // ------------------------------------------------------------
  // Reporting and expectations
  // ------------------------------------------------------------
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  // Overflow, underflow and slip flags one buffer access should raise
  function automatic logic [2:0] slip_flags(input logic w, input logic r,
                                            input logic f, input logic e);
    return {w & f, r & e, (w & f) | (r & e)};
  endfunction

  function automatic logic [31:0] exp_status(input logic cas,
                                             input logic crc);
    return {27'h000_0000, cas, crc, exp_sticky};
  endfunction

  // ------------------------------------------------------------
  // Bus master: every change lands by NBA just after a rising edge
  // ------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] exp_resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge CLK_I);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever begin
      @(posedge CLK_I);
      if (BVALID === 1'b1) break;
      if (!aw_done && AWREADY === 1'b1) begin
        aw_done = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w_done && WREADY === 1'b1) begin
        w_done = 1'b1;
        WVALID <= 1'b0;
      end
    end
    BREADY <= 1'b0;
    check({30'h0, BRESP}, {30'h0, exp_resp}, "write response");
  endtask

  // Read a word and compare data and response
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
    logic ar_done;
    logic [31:0] d;
    logic [1:0] r;
    ar_done = 1'b0;
    @(posedge CLK_I);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= !rd_slow;
    forever begin
      @(posedge CLK_I);
      if (RVALID === 1'b1) begin
        // A slow master raises RREADY only once the answer stands
        if (RREADY !== 1'b1) begin
          RREADY <= 1'b1;
          @(posedge CLK_I);
        end
        d = RDATA;
        r = RRESP;
        break;
      end
      if (!ar_done && ARREADY === 1'b1) begin
        ar_done = 1'b1;
        ARVALID <= 1'b0;
      end
    end
    RREADY <= 1'b0;
    check(d, exp, "read data");
    check({30'h0, r}, {30'h0, exp_resp}, "read response");
  endtask

  // A status read returns the pre-clear value, then sticky bits drop
  task automatic status_check(input logic cas, input logic crc);
    rd_check(RSM_OFF_STATUS, exp_status(cas, crc), RSM_RESP_OKAY);
    exp_sticky = 3'h0;
  endtask

  // One slip buffer access with the given full and empty levels
  task automatic slip_event(input logic w, input logic r, input logic f,
                            input logic e);
    @(posedge CLK_I);
    RX_SLIP_WRITE_I <= w;
    RX_SLIP_READ_I <= r;
    RX_SLIP_FULL_I <= f;
    RX_SLIP_EMPTY_I <= e;
    @(posedge CLK_I);
    RX_SLIP_WRITE_I <= 1'b0;
    RX_SLIP_READ_I <= 1'b0;
    #1;
    check(RX_FRAME_DELETE_O, w & f, "frame delete");
    check(RX_FRAME_REPEAT_O, r & e, "frame repeat");
    exp_sticky = exp_sticky | slip_flags(w, r, f, e);
    @(posedge CLK_I);
    #1;
    check({RX_FRAME_DELETE_O, RX_FRAME_REPEAT_O}, 0, "single pulse");
  endtask

  // Pulse bits: CAS good, CAS errored, CRC good, CRC errored
  task automatic lock_pulse(input logic [3:0] p);
    @(posedge CLK_I);
    {CAS_ALIGN_OK_I, CAS_ALIGN_ERR_I, CRC_ALIGN_OK_I, CRC_ALIGN_ERR_I} <= p;
    @(posedge CLK_I);
    {CAS_ALIGN_OK_I, CAS_ALIGN_ERR_I, CRC_ALIGN_OK_I, CRC_ALIGN_ERR_I} <= 4'h0;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  task automatic t_reset();
    check(IRQ_O, 0, "irq after reset");
    status_check(1'b0, 1'b0);
    rd_check(RSM_OFF_IRQ_MASK, 32'h0000_0000, RSM_RESP_OKAY);
    rd_check(RSM_OFF_CTRL, 32'h0001_2223, RSM_RESP_OKAY);
    rd_check(8'h0C, 32'h0000_0000, RSM_RESP_SLVERR);
    axi_write(8'h0C, 32'hFFFF_FFFF, RSM_RESP_SLVERR);
    rd_check(RSM_OFF_CTRL, 32'h0001_2223, RSM_RESP_OKAY);
    $display("Test reset done");
  endtask

  task automatic t_slip();
    axi_write(RSM_OFF_IRQ_MASK, 32'h0000_0007, RSM_RESP_OKAY);
    slip_event(1'b1, 1'b0, 1'b1, 1'b0);
    check(IRQ_O, 1, "irq on overflow");
    status_check(1'b0, 1'b0);
    check(IRQ_O, 0, "irq after read");
    status_check(1'b0, 1'b0);
    slip_event(1'b0, 1'b1, 1'b0, 1'b1);
    status_check(1'b0, 1'b0);
    slip_event(1'b1, 1'b0, 1'b0, 1'b0);
    slip_event(1'b0, 1'b1, 1'b0, 1'b0);
    status_check(1'b0, 1'b0);
    slip_event(1'b1, 1'b1, 1'b1, 1'b1);
    status_check(1'b0, 1'b0);
    axi_write(RSM_OFF_IRQ_MASK, 32'h0000_0000, RSM_RESP_OKAY);
    slip_event(1'b1, 1'b0, 1'b1, 1'b0);
    check(IRQ_O, 0, "masked irq");
    axi_write(RSM_OFF_STATUS, 32'h0000_0001, RSM_RESP_OKAY);
    exp_sticky = 3'h4;
    axi_write(RSM_OFF_IRQ_MASK, 32'h0000_0004, RSM_RESP_OKAY);
    check(IRQ_O, 1, "irq unmasked");
    status_check(1'b0, 1'b0);
    $display("Test slip done");
  endtask

  task automatic t_lock();
    lock_pulse(4'h8);
    status_check(1'b1, 1'b0);
    lock_pulse(4'h4);
    status_check(1'b1, 1'b0);
    lock_pulse(4'h4);
    status_check(1'b0, 1'b0);
    lock_pulse(4'h2);
    lock_pulse(4'h1);
    lock_pulse(4'h2);
    status_check(1'b0, 1'b0);
    lock_pulse(4'h2);
    status_check(1'b0, 1'b1);
    lock_pulse(4'h8);
    status_check(1'b1, 1'b1);
    axi_write(RSM_OFF_CTRL, 32'h0001_2213, RSM_RESP_OKAY);
    lock_pulse(4'h4);
    status_check(1'b0, 1'b1);
    axi_write(RSM_OFF_CTRL, 32'h0001_2220, RSM_RESP_OKAY);
    status_check(1'b0, 1'b0);
    axi_write(RSM_OFF_CTRL, 32'h0001_2223, RSM_RESP_OKAY);
    status_check(1'b0, 1'b0);
    $display("Test lock done");
  endtask

  // A frozen block must ignore buffer events and refuse bus beats
  task automatic t_freeze();
    @(posedge CLK_I);
    CE_I <= 1'b0;
    {RX_SLIP_WRITE_I, RX_SLIP_READ_I} <= 2'b11;
    {RX_SLIP_FULL_I, RX_SLIP_EMPTY_I} <= 2'b11;
    repeat (2) @(posedge CLK_I);
    check(RX_FRAME_DELETE_O, 0, "frozen delete");
    check(RX_FRAME_REPEAT_O, 0, "frozen repeat");
    check(AWREADY, 0, "frozen ready");
    {RX_SLIP_WRITE_I, RX_SLIP_READ_I} <= 2'b00;
    CE_I <= 1'b1;
    status_check(1'b0, 1'b0);
    $display("Test freeze done");
  endtask

  // Random buffer traffic; the mask is redrawn at every status read
  task automatic t_random();
    logic [3:0] v;
    logic [2:0] m;
    for (int i = 0; i < 32; i++) begin
      v = 4'($urandom);
      slip_event(v[3], v[2], v[1], v[0]);
      if (i % 4 == 3) begin
        rd_slow = i[2];
        m = 3'($urandom);
        axi_write(RSM_OFF_IRQ_MASK, {29'h0, m}, RSM_RESP_OKAY);
        check(IRQ_O, |(exp_sticky & m), "random irq");
        status_check(1'b0, 1'b0);
      end
    end
    $display("Test random done");
  endtask

  // Watchdog against a hung handshake
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      summarize();
    end
  end

  initial begin
    {AWADDR, ARADDR, AWPROT, ARPROT, WDATA} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {CAS_ALIGN_OK_I, CAS_ALIGN_ERR_I, CRC_ALIGN_OK_I, CRC_ALIGN_ERR_I} = '0;
    {RX_SLIP_WRITE_I, RX_SLIP_READ_I, RX_SLIP_FULL_I, RX_SLIP_EMPTY_I} = '0;
    WSTRB = 4'hF;
    CE_I = 1'b1;
    RST_I = 1'b1;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    exp_sticky = 3'h0;
    rd_slow = 1'b0;
    seed = $urandom(97737);
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_reset();
    t_slip();
    t_lock();
    t_freeze();
    t_random();
    summarize();
  end
endmodule // test_rx_slip_and_multiframe_status
